// [i2bm_monitor.sv]
// Purpose: Bus error monitor and sticky error flags of an I2C controller
// Assumes: Sequencer signals share CLOCK; bus pins are asynchronous
// Notes:   Pins pass two flops before any logic reads them
// Functional notes
// - Analog contention: filtered SDA vs driven, on SCL
// - Read bits latched with filtered SDA and SCL
// - Digital contention on raw lines when settled
// - Glitch: two consecutive samples disagree with filter
// - Noise: over quarter of samples disagree
// - Redundant read: compare first and second data
// - Redundant check only when its enable is one
// - Timeout flag, only when timeout enable is one
// - Flags clear on written zero; one ignored
// - All flags zero after reset
// - State code: 00 idle,01 busy,10 error,11 done
// - Address not acknowledged sets the nack flag
`timescale 1ns/1ps
`default_nettype none
module i2bm_monitor
    import i2bm_pkg::*;
#(
    parameter int FILT_D  = FILT_DEPTH,
    parameter int NWIN    = NOISE_WIN,
    parameter int TO_CYC  = TIMEOUT_CYC
) (
    input  wire logic        CLOCK,
    input  wire logic        RSTN,
    input  wire logic [3:0]  AWADDR,
    input  wire logic        AWVALID,
    output var  logic        AWREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output var  logic        WREADY,
    output var  logic [1:0]  BRESP,
    output var  logic        BVALID,
    input  wire logic        BREADY,
    input  wire logic [3:0]  ARADDR,
    input  wire logic        ARVALID,
    output var  logic        ARREADY,
    output var  logic [31:0] RDATA,
    output var  logic [1:0]  RRESP,
    output var  logic        RVALID,
    input  wire logic        RREADY,
    input  wire logic        SCL_RAW,
    input  wire logic        SDA_RAW,
    input  wire logic        SCL_AF,
    input  wire logic        SDA_AF,
    input  wire logic        SCL_DRV,
    input  wire logic        SDA_DRV,
    input  wire logic        SDA_OWN,
    input  wire logic        LINES_SETTLED,
    input  wire logic        ADDR_ACK_SLOT,
    input  wire logic        TXN_START,
    input  wire logic        TXN_DONE,
    input  wire logic        RD_PASS,
    output var  logic        IRQ,
    output var  logic [1:0]  STATE_CODE
);
    // ==========================================================
    // Parameter checks
    localparam int CW = $clog2(NWIN + 1);
    if (FILT_D < 2) begin : g_bad_filt
        $error("FILT_D must be at least 2");
    end
    if (NWIN < 4 || TO_CYC < 2) begin : g_bad_win
        $error("NWIN or TO_CYC too small");
    end

    // ==========================================================
    // State
    typedef struct packed {
        logic [3:0]                  s1;
        logic [3:0]                  s2;
        logic                        scl_prev;
        logic [1:0][FILT_D-1:0]      hist;
        logic [1:0]                  filt;
        logic [1:0]                  dis_prev;
        logic [1:0][CW-1:0]          dis_cnt;
        logic [CW-1:0]               win_cnt;
        logic [31:0]                 to_cnt;
        logic [7:0]                  flags;
        logic [7:0]                  mask;
        logic [1:0]                  ctrl;
        i2bm_state_t                 state;
        logic                        txn_err;
        logic [31:0]                 rx;
        logic [31:0]                 first;
        logic                        aw_have;
        logic [3:0]                  aw_addr;
        logic                        w_have;
        logic [31:0]                 wdata;
        logic [3:0]                  wstrb;
        logic                        awready;
        logic                        wready;
        logic                        bvalid;
        logic [1:0]                  bresp;
        logic                        arready;
        logic                        rvalid;
        logic [1:0]                  rresp;
        logic [31:0]                 rdata;
        logic                        irq;
    } i2bm_regs_t;

    i2bm_regs_t q_r;
    i2bm_regs_t q_nxt;

    // Syncs and filter reset to the idle-high bus level,
    // so no false SCL edge or glitch follows reset
    localparam i2bm_regs_t RST_REGS = '{
        flags   : RST_FLAGS,
        mask    : RST_MASK,
        ctrl    : RST_CTRL,
        state   : ST_IDLE,
        filt    : 2'b11,
        hist    : '1,
        s1      : 4'hF,
        s2      : 4'hF,
        scl_prev: 1'b1,
        default : '0
    };

    // ==========================================================
    // Next state
    always_comb begin
        logic [7:0]  ev;
        logic        scl_rise;
        logic        do_wr;
        logic        dis;
        logic [1:0]  ln;
        logic [CW-1:0] dc;
        logic        win_end;
        ev       = 8'h00;
        q_nxt    = q_r;
        dis      = 1'b0;
        dc       = '0;
        ln       = 2'b00;
        scl_rise = 1'b0;
        do_wr    = 1'b0;
        win_end  = 1'b0;
        // Second flop alone reads the first
        q_nxt.s1 = {SDA_AF, SCL_AF, SDA_RAW, SCL_RAW};
        q_nxt.s2 = q_r.s1;
        ln       = q_r.s2[1:0];
        scl_rise = q_r.s2[2] & ~q_r.scl_prev;
        q_nxt.scl_prev = q_r.s2[2];

        // Filtered SCL edge drives both checks and capture
        if (scl_rise) begin
            if (SDA_OWN && (q_r.s2[3] != SDA_DRV)) begin
                ev[BIT_ANACONT] = 1'b1;
            end
            if (ADDR_ACK_SLOT && q_r.s2[3]) begin
                ev[BIT_NACK] = 1'b1;
            end
            if (!SDA_OWN && !ADDR_ACK_SLOT && q_r.state == ST_BUSY) begin
                q_nxt.rx = {q_r.rx[30:0], q_r.s2[3]};
            end
        end

        // Raw lines must match what is driven once settled
        // Drive is not delayed to match the syncs; it must hold while settled
        if (LINES_SETTLED && ((ln[0] != SCL_DRV) || (SDA_OWN && ln[1] != SDA_DRV))) begin
            ev[BIT_CONT] = 1'b1;
        end

        // Oversampling filter per line; new value only when unanimous
        win_end = LINES_SETTLED && (q_r.win_cnt == CW'(NWIN - 1));
        if (LINES_SETTLED) begin
            q_nxt.win_cnt = win_end ? '0 : q_r.win_cnt + CW'(1);
        end
        for (int i = 0; i < 2; i++) begin
            q_nxt.hist[i] = {q_r.hist[i][FILT_D-2:0], ln[i]};
            if (&q_r.hist[i]) begin
                q_nxt.filt[i] = 1'b1;
            end else if (~|q_r.hist[i]) begin
                q_nxt.filt[i] = 1'b0;
            end
            dis = ln[i] != q_r.filt[i];
            q_nxt.dis_prev[i] = LINES_SETTLED & dis;
            if (LINES_SETTLED && dis && q_r.dis_prev[i]) begin
                ev[BIT_GLITCH] = 1'b1;
            end
            if (LINES_SETTLED) begin
                dc = q_r.dis_cnt[i] + CW'(dis);
                // Count times four beats the whole window
                if (win_end && (32'(dc) * 4 > NWIN)) begin
                    ev[BIT_NOISE] = 1'b1;
                end
                q_nxt.dis_cnt[i] = win_end ? '0 : dc;
            end
        end

        // Timeout counts only while busy and enabled
        // Count stops at the limit so one stuck transaction flags once
        if (q_r.state == ST_BUSY && q_r.ctrl[BIT_TOEN]) begin
            if (q_r.to_cnt != 32'(TO_CYC)) begin
                q_nxt.to_cnt = q_r.to_cnt + 32'd1;
            end
            if (q_r.to_cnt == 32'(TO_CYC - 1)) begin
                ev[BIT_TIMEOUT] = 1'b1;
            end
        end else begin
            q_nxt.to_cnt = 32'd0;
        end

        // Transaction end and redundant read check
        if (TXN_DONE && q_r.state == ST_BUSY) begin
            if (!RD_PASS) begin
                q_nxt.first = q_r.rx;
            end else if (q_r.ctrl[BIT_RDTREN] && q_r.rx != q_r.first) begin
                ev[BIT_RDTR] = 1'b1;
            end
        end

        // ==========================================================
        // AXI4-Lite write path
        if (AWVALID && q_r.awready) begin
            q_nxt.aw_have = 1'b1;
            q_nxt.aw_addr = AWADDR;
        end
        if (WVALID && q_r.wready) begin
            q_nxt.w_have = 1'b1;
            q_nxt.wdata  = WDATA;
            q_nxt.wstrb  = WSTRB;
        end
        do_wr = q_r.aw_have && q_r.w_have && !q_r.bvalid;
        if (q_r.bvalid && BREADY) begin
            q_nxt.bvalid = 1'b0;
        end
        if (do_wr) begin
            q_nxt.aw_have = 1'b0;
            q_nxt.w_have  = 1'b0;
            q_nxt.bvalid  = 1'b1;
            q_nxt.bresp   = RESP_OKAY;
            case (q_r.aw_addr)
                OFS_STATUS: begin
                    // Zero clears; a new event still wins below
                    if (q_r.wstrb[0]) begin
                        q_nxt.flags = q_r.flags & q_r.wdata[7:0];
                    end
                    if (q_r.wstrb[1] && q_r.wdata[15:14] == 2'b00 && q_r.state != ST_BUSY) begin
                        q_nxt.state = ST_IDLE;
                    end
                end
                OFS_CTRL: begin
                    if (q_r.wstrb[0]) begin
                        q_nxt.ctrl = q_r.wdata[1:0];
                    end
                end
                OFS_MASK: begin
                    if (q_r.wstrb[0]) begin
                        q_nxt.mask = q_r.wdata[7:0];
                    end
                end
                OFS_RXDATA: begin
                    q_nxt.bresp = RESP_OKAY;
                end
                default: begin
                    // Unmapped offset: answer an error, change nothing
                    q_nxt.bresp = RESP_SLVERR;
                end
            endcase
        end
        // Ready only while the holding slot is empty
        q_nxt.awready = ~q_nxt.aw_have;
        q_nxt.wready  = ~q_nxt.w_have;

        // Set beats clear
        q_nxt.flags = q_nxt.flags | ev;

        // ==========================================================
        // Transaction state code
        if (q_r.state == ST_BUSY) begin
            q_nxt.txn_err = q_r.txn_err | (|ev);
            if (TXN_DONE) begin
                q_nxt.state = (q_r.txn_err || (|ev)) ? ST_ERR : ST_DONE;
            end
        end else if (TXN_START) begin
            q_nxt.state   = ST_BUSY;
            q_nxt.txn_err = 1'b0;
            q_nxt.rx      = 32'h0000_0000;
        end

        // ==========================================================
        // AXI4-Lite read path
        // Read data is the state before the edge that takes the address
        if (q_r.rvalid && RREADY) begin
            q_nxt.rvalid = 1'b0;
        end
        if (ARVALID && q_r.arready) begin
            q_nxt.rvalid = 1'b1;
            q_nxt.rresp  = RESP_OKAY;
            q_nxt.rdata  = 32'h0000_0000;
            case (ARADDR)
                OFS_STATUS: begin
                    q_nxt.rdata[15:14] = q_r.state;
                    q_nxt.rdata[7:0]   = q_r.flags;
                end
                OFS_CTRL: begin
                    q_nxt.rdata[1:0] = q_r.ctrl;
                end
                OFS_MASK: begin
                    q_nxt.rdata[7:0] = q_r.mask;
                end
                OFS_RXDATA: begin
                    q_nxt.rdata = q_r.rx;
                end
                default: begin
                    q_nxt.rresp = RESP_SLVERR;
                end
            endcase
        end
        q_nxt.arready = ~q_nxt.rvalid;

        // Taken from the next state so IRQ moves at the same edge as the flags
        q_nxt.irq = |(q_nxt.flags & q_nxt.mask);
    end

    // ==========================================================
    // Registers
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            q_r <= RST_REGS;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign AWREADY    = q_r.awready;
    assign WREADY     = q_r.wready;
    assign BVALID     = q_r.bvalid;
    assign BRESP      = q_r.bresp;
    assign ARREADY    = q_r.arready;
    assign RVALID     = q_r.rvalid;
    assign RRESP      = q_r.rresp;
    assign RDATA      = q_r.rdata;
    assign IRQ        = q_r.irq;
    assign STATE_CODE = q_r.state;
endmodule // i2bm_monitor
`default_nettype wire

// [i2bm_monitor_bench.sv]
// Purpose: Self-checking bench for the bus error monitor
// Assumes: 250 MHz clock, timeout shortened to 200 cycles
// Notes:   Bench plays the sequencer; target model pulls SDA
`timescale 1ns/1ps
`default_nettype none
module i2bm_monitor_bench;
    import i2bm_pkg::*;
    // ==========================================
    // Signals
    logic CLOCK = 0, RSTN = 0, AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0, IRQ;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, SCL_RAW, SDA_RAW, SCL_AF, SDA_AF;
    logic SCL_DRV = 1, SDA_DRV = 1, SDA_OWN = 0, LINES_SETTLED = 0, ADDR_ACK_SLOT = 0;
    logic TXN_START = 0, TXN_DONE = 0, RD_PASS = 0, tgt = 0;
    logic [3:0]  AWADDR = 0, ARADDR = 0, WSTRB = 4'hF;
    logic [31:0] WDATA = 0, RDATA;
    logic [1:0]  BRESP, RRESP, STATE_CODE;
    logic [1:0]  b_resp;
    int error_cnt = 0, total_checks = 0;
    i2bm_monitor #(.TO_CYC(200)) i_i2bm_monitor (.*);
    i2bm_target i_i2bm_target (.scl_drv(SCL_DRV), .sda_drv(SDA_DRV), .sda_own(SDA_OWN), .pull_low(tgt),
        .scl_raw(SCL_RAW), .sda_raw(SDA_RAW), .scl_af(SCL_AF), .sda_af(SDA_AF));
    always #2 CLOCK = ~CLOCK;
    // ==========================================
    // Helpers
    task end_sim;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge CLOCK);
    endtask
    // Timeout of any bus wait counts as a mismatch
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        int n;
        AWADDR <= a; WDATA <= d; AWVALID <= 1'h1; WVALID <= 1'h1; BREADY <= 1'h1;
        for (n = 0; n < 99; n++) begin
            @(posedge CLOCK);
            if (AWVALID && AWREADY) AWVALID <= 1'h0;
            if (WVALID && WREADY) WVALID <= 1'h0;
            if (BVALID) begin
                b_resp = BRESP;
                break;
            end
        end
        if (n == 99) begin error_cnt++; end_sim; end
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        ARADDR <= a; ARVALID <= 1'h1; RREADY <= 1'h1;
        for (n = 0; n < 99; n++) begin
            @(posedge CLOCK);
            if (ARVALID && ARREADY) ARVALID <= 1'h0;
            if (RVALID) break;
        end
        d = RDATA; r = RRESP;
        if (n == 99) begin error_cnt++; end_sim; end
    endtask
    task automatic rchk(input logic [3:0] a, input logic [31:0] e);
        logic [31:0] d; logic [1:0] r;
        rd(a, d, r);
        chk("register", d, e);
    endtask
    task automatic go(input logic done);
        TXN_START <= !done; TXN_DONE <= done; cyc(1); TXN_START <= 1'h0; TXN_DONE <= 1'h0;
    endtask
    task automatic spulse;
        SCL_DRV <= 1'h0; cyc(16); SCL_DRV <= 1'h1; cyc(15);
    endtask
    // Read: address ack slot, three data bits from the target
    task automatic txn(input logic [2:0] b, input logic ack, input logic pass);
        go(0); ADDR_ACK_SLOT <= 1'h1; tgt <= ack; spulse; ADDR_ACK_SLOT <= 1'h0;
        for (int i = 2; i >= 0; i--) begin tgt <= !b[i]; spulse; end
        tgt <= 1'h0; RD_PASS <= pass; go(1); cyc(4);
    endtask
    // ==========================================
    // Scenarios
    task automatic t_reset;
        logic [31:0] d; logic [1:0] r;
        chk("state", STATE_CODE, 0);
        rchk(OFS_STATUS, 0);
        rchk(OFS_CTRL, 0);
        rchk(OFS_MASK, 0);
        rd(4'h2, d, r); chk("unmapped", {d[29:0], r}, RESP_SLVERR);
        wr(4'h2, 32'h0000_00FF); chk("bresp", b_resp, RESP_SLVERR);
        rchk(OFS_MASK, 0);
        wr(OFS_MASK, 32'h0000_00FF); chk("bresp", b_resp, RESP_OKAY);
    endtask
    task automatic t_contention;
        go(0); SDA_OWN <= 1'h1; tgt <= 1'h1; spulse; LINES_SETTLED <= 1'h1; cyc(10);
        LINES_SETTLED <= 1'h0; tgt <= 1'h0; SDA_OWN <= 1'h0; cyc(4); go(1); cyc(4);
        rchk(OFS_STATUS, 32'h0000_8030);
        chk("irq", IRQ, 1);
        wr(OFS_STATUS, 0); rchk(OFS_STATUS, 0);
    endtask
    task automatic t_glitch;
        LINES_SETTLED <= 1'h1; cyc(4); tgt <= 1'h1; cyc(2); tgt <= 1'h0; cyc(8);
        rchk(OFS_STATUS, 32'h0000_0008);
        wr(OFS_STATUS, 0); tgt <= 1'h1; cyc(3); tgt <= 1'h0; cyc(1); tgt <= 1'h1; cyc(3); tgt <= 1'h0; cyc(12);
        LINES_SETTLED <= 1'h0; rchk(OFS_STATUS, 32'h0000_000C);
        wr(OFS_STATUS, 0);
    endtask
    task automatic t_read;
        wr(OFS_CTRL, 32'h0000_0002); txn(3'h5, 1, 0);
        rchk(OFS_RXDATA, 32'h0000_0005);
        rchk(OFS_STATUS, 32'h0000_C000);
        txn(3'h3, 1, 1); rchk(OFS_STATUS, 32'h0000_8002);
        wr(OFS_STATUS, 0); wr(OFS_CTRL, 0); txn(3'h5, 1, 0); txn(3'h3, 1, 1);
        rchk(OFS_STATUS, 32'h0000_C000);
        txn(3'h5, 0, 0); rchk(OFS_STATUS, 32'h0000_8080);
    endtask
    task automatic t_sticky;
        wr(OFS_STATUS, 32'h0000_C0FF); rchk(OFS_STATUS, 32'h0000_8080);
        wr(OFS_MASK, 0); cyc(2); chk("irq", IRQ, 0);
        wr(OFS_MASK, 32'h0000_00FF); cyc(2); chk("irq", IRQ, 1);
        wr(OFS_STATUS, 32'h0000_C07F); rchk(OFS_STATUS, 32'h0000_8000);
        cyc(2); chk("irq", IRQ, 0);
    endtask
    task automatic t_timeout;
        for (int en = 0; en < 2; en++) begin
            wr(OFS_CTRL, en); go(0); cyc(220); go(1); cyc(4);
            rchk(OFS_STATUS, en ? 32'h0000_8001 : 32'h0000_C000);
        end
    endtask
    initial begin
        cyc(3); RSTN <= 1'h1; cyc(8);
        t_reset; t_contention; t_glitch; t_read; t_sticky; t_timeout;
        end_sim;
    end
endmodule // i2bm_monitor_bench
`default_nettype wire

// [i2bm_monitor_properties.sv]
// Purpose: Concurrent checks on the bus error monitor ports
// Assumes: One clock domain, async active-low reset
// Notes:   Flags are seen only through status reads and IRQ
`timescale 1ns/1ps
`default_nettype none
module i2bm_monitor_properties
    import i2bm_pkg::*;
#(
    parameter int FILT_D = FILT_DEPTH,
    parameter int NWIN   = NOISE_WIN,
    parameter int TO_CYC = TIMEOUT_CYC
) (
    input wire logic        CLOCK,
    input wire logic        RSTN,
    input wire logic        AWVALID,
    input wire logic        AWREADY,
    input wire logic        WVALID,
    input wire logic        WREADY,
    input wire logic        BVALID,
    input wire logic [3:0]  ARADDR,
    input wire logic        ARVALID,
    input wire logic        ARREADY,
    input wire logic [31:0] RDATA,
    input wire logic        RVALID,
    input wire logic        TXN_START,
    input wire logic        TXN_DONE,
    input wire logic        IRQ,
    input wire logic [1:0]  STATE_CODE
);
    // ==========================================
    // Helper state
    logic rd_sts_r;
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            rd_sts_r <= 1'h0;
        end else begin
            if (ARVALID && ARREADY) rd_sts_r <= (ARADDR == OFS_STATUS);
        end
    end
    // ==========================================
    // Properties
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RSTN);
    property p_rst_idle;
        $rose(RSTN) |-> STATE_CODE == ST_IDLE && !IRQ;
    endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("state or irq set after reset");
    property p_start_busy;
        TXN_START && STATE_CODE != ST_BUSY |=> STATE_CODE == ST_BUSY;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("start did not enter busy");
    property p_busy_hold;
        STATE_CODE == ST_BUSY && !TXN_DONE |=> STATE_CODE == ST_BUSY;
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy left without done");
    property p_done_end;
        STATE_CODE == ST_BUSY && TXN_DONE |=> STATE_CODE inside {ST_DONE, ST_ERR};
    endproperty
    a_done_end: assert property (p_done_end) else $error("end of transaction gave bad state");
    property p_idle_hold;
        STATE_CODE == ST_IDLE && !TXN_START |=> STATE_CODE == ST_IDLE;
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("idle left without start");
    // Writes in flight show as a busy address or data slot
    property p_end_hold;
        STATE_CODE[1] && !TXN_START && AWREADY && WREADY && !AWVALID && !WVALID |=> $stable(STATE_CODE);
    endproperty
    a_end_hold: assert property (p_end_hold) else $error("end state moved with no cause");
    property p_status_rd;
        $rose(RVALID) && rd_sts_r |-> RDATA[15:14] == $past(STATE_CODE) && !RDATA[6];
    endproperty
    a_status_rd: assert property (p_status_rd) else $error("status read disagrees with state");
    // Sticky flags: IRQ may only drop at the edge a write is performed
    property p_irq_fall;
        $fell(IRQ) |-> $rose(BVALID);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell without a write");
endmodule // i2bm_monitor_properties
bind i2bm_monitor i2bm_monitor_properties #(.FILT_D(FILT_D), .NWIN(NWIN), .TO_CYC(TO_CYC)) i_props (
    .CLOCK, .RSTN, .AWVALID, .AWREADY, .WVALID, .WREADY, .BVALID, .ARADDR, .ARVALID,
    .ARREADY, .RDATA, .RVALID, .TXN_START, .TXN_DONE, .IRQ, .STATE_CODE);
`default_nettype wire

// [i2bm_pkg.sv]
// Purpose: Constants and types for the I2C bus error monitor
// Assumes: 250 MHz system clock, AXI4-Lite with 32-bit data
// Notes:   Register map is word aligned
package i2bm_pkg;
    // ==========================================================
    // Register map
    localparam logic [3:0] OFS_STATUS = 4'h0;
    localparam logic [3:0] OFS_CTRL   = 4'h4;
    localparam logic [3:0] OFS_MASK   = 4'h8;
    localparam logic [3:0] OFS_RXDATA = 4'hC;
    // ==========================================================
    // Flag, state field and control bit positions
    localparam int BIT_NACK    = 7;
    localparam int BIT_ANACONT = 5;
    localparam int BIT_CONT    = 4;
    localparam int BIT_GLITCH  = 3;
    localparam int BIT_NOISE   = 2;
    localparam int BIT_RDTR    = 1;
    localparam int BIT_TIMEOUT = 0;
    localparam int BIT_STATE   = 14;
    localparam int BIT_TOEN    = 0;
    localparam int BIT_RDTREN  = 1;
    // ==========================================================
    // Reset values and response codes
    localparam logic [7:0] RST_FLAGS = 8'h00;
    localparam logic [7:0] RST_MASK  = 8'h00;
    localparam logic [1:0] RST_CTRL  = 2'h0;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ==========================================================
    // Timing
    localparam int CLK_MHZ     = 250;
    localparam int TIMEOUT_US  = 1000;
    localparam int TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;
    localparam int FILT_DEPTH  = 4;
    localparam int NOISE_WIN   = 8;
    // ==========================================================
    // Controller state code
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_BUSY = 2'b01,
        ST_DONE = 2'b11,
        ST_ERR  = 2'b10
    } i2bm_state_t;
endpackage

// [i2bm_target.sv]
// Purpose: Bus wires and a target that pulls SDA low on command
// Assumes: Pull-ups on both lines
// Notes:   Analog filter modelled as a plain delay
`timescale 1ns/1ps
`default_nettype none
module i2bm_target #(
    parameter int AF_NS = 20
) (
    input  wire logic scl_drv,
    input  wire logic sda_drv,
    input  wire logic sda_own,
    input  wire logic pull_low,
    output var  logic scl_raw,
    output var  logic sda_raw,
    output var  logic scl_af,
    output var  logic sda_af
);
    // ==========================================
    // Wires: released lines float high
    logic scl_d = 1'h1;
    logic sda_d = 1'h1;
    always_comb scl_raw = scl_drv;
    always_comb sda_raw = (sda_drv | !sda_own) & !pull_low;
    always @(scl_raw) scl_d <= #AF_NS scl_raw;
    always @(sda_raw) sda_d <= #AF_NS sda_raw;
    always_comb scl_af = scl_d;
    always_comb sda_af = sda_d;
endmodule // i2bm_target
`default_nettype wire
